// >>> inc/rcs_pkg.sv
// Purpose: shared constants of the timekeeping control/status block
// Assumes: byte-wide configuration bus, one clock
// Notes:   offsets are byte addresses on the configuration bus
package rcs_pkg;
   // configuration bus widths
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 8;
   // register map
   localparam logic [7:0]  COUNTER_BASE  = 8'h40;
   localparam logic [7:0]  MATCH_BASE    = 8'h48;
   localparam logic [7:0]  MATCHBIT_BASE = 8'h50;
   localparam logic [7:0]  CTRL_ADDR     = 8'h58;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ = 8'h00;
   // control field positions
   localparam int unsigned BIT_RTC_RST   = 7;
   localparam int unsigned BIT_CNT_EN    = 6;
   localparam int unsigned BIT_MATCH_EN  = 5;
   localparam int unsigned BIT_MODE_HI   = 4;
   localparam int unsigned BIT_MODE_LO   = 3;
   localparam int unsigned BIT_CLR_MATCH = 2;
   localparam int unsigned BIT_CLR_N     = 1;
   localparam int unsigned BIT_XTAL_SEL  = 0;
   // counter shape and timing counts
   localparam int unsigned COUNT_W       = 40;
   localparam int unsigned PRESCALE_DIV  = 128;
   localparam int unsigned START_EDGES   = 64;
   localparam int unsigned RELEASE_CYC   = 2;
endpackage

// >>> hdl/rcs_top.sv
// Purpose: control/status logic of a 40-bit prescaled real-time counter
// Assumes: crystal clock input is synchronous to core_clk_in; reads answer next cycle
// Notes:   registers are byte wide, reached over the configuration bus pins
// Functional notes
// - control bit 7 holds timekeeping in reset; release two bus clocks after clear
// - counter advances only with enable bit 6 set and reset bit clear
// - first increment after enable comes after 64 crystal rising edges
// - clearing enable stops prescaler, counter contents kept
// - preload of counter accepted only while counting disabled
// - match enable bit 5 drives both match outputs high on equality
// - match enable clear forces both match outputs low
// - bits 4:3, reset 00, drive the crystal mode output
// - bit 2 set clears counter synchronously on match, else counts on
// - clear on match suppressed when whole match register is zero
// - control bit 1 low clears counter to zero
// - bit 0 drives oscillator select; zero means fabric enable, mode ignored
// - select bit one enables oscillator with mode from mode field
// - crystal clock divided by 128 before incrementing counter
// - counter byte 0 reads live and captures the hold register; upper bytes read from the hold
`timescale 1ns/1ns
module rcs_top
#(
   parameter int unsigned CNT_W     = rcs_pkg::COUNT_W,
   parameter int unsigned PRE_DIV   = rcs_pkg::PRESCALE_DIV,
   parameter int unsigned FIRST_EDG = rcs_pkg::START_EDGES
)
(
   input  wire logic                       core_clk_in,
   input  wire logic                       rst_n_in,
   input  wire logic [rcs_pkg::ADDR_W-1:0] cfg_addr_in,
   input  wire logic [rcs_pkg::DATA_W-1:0] cfg_wdata_in,
   input  wire logic                       cfg_wen_in,
   input  wire logic                       cfg_ren_in,
   output logic      [rcs_pkg::DATA_W-1:0] cfg_rdata_out,
   input  wire logic                       crystal_count_clock_in,
   output logic                            fabric_match_out,
   output logic                            power_monitor_match_out,
   output logic      [1:0]                 osc_mode_out,
   output logic                            osc_select_out
);
   import rcs_pkg::*;

   localparam int unsigned NBYTES = CNT_W / 8;
   localparam int unsigned PRE_W  = $clog2(PRE_DIV);
   localparam logic [PRE_W-1:0] PRE_LAST  = PRE_W'(PRE_DIV - 1);
   localparam logic [PRE_W-1:0] PRE_START = PRE_W'(PRE_DIV - FIRST_EDG);
   localparam logic [1:0]       REL_LOAD  = 2'(RELEASE_CYC);

   // parameter sanity, refused at elaboration
   if ((CNT_W % 8) != 0 || CNT_W < 8 || CNT_W > 64)
   begin : g_bad_width
      $error("counter width must be 8..64 in whole bytes");
   end
   if (PRE_DIV < 2 || PRE_DIV > 65536 || (PRE_DIV & (PRE_DIV - 1)) != 0)
   begin : g_bad_div
      $error("prescale divisor must be a power of two up to 65536");
   end
   // helper counters below are 8 and 16 bits wide
   if (FIRST_EDG < 1 || FIRST_EDG > PRE_DIV || FIRST_EDG > 256)
   begin : g_bad_first
      $error("first-increment edge count must be 1..divisor, at most 256");
   end

   logic [7:0]       ctrl_q;
   logic [1:0]       rel_q;
   logic             rtc_busy;
   logic             running;
   logic             xtal_prev_q;
   logic             xtal_edge;
   logic [PRE_W-1:0] pre_q;
   logic             tick;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] match_q;
   logic [CNT_W-1:0] hold_q;
   logic             hit;
   logic             match_zero;
   logic             clr_cond;
   logic [4:0]       blk;
   logic [2:0]       idx;
   logic             idx_ok;
   logic             wr_cnt;
   logic             wr_match;
   logic             wr_ctrl;
   logic             rd_cnt0;
   logic [7:0]       rdata_d;
   logic [7:0]       rdata_q;
   logic [CNT_W-1:0] bits_eq;

   // address decode
   assign blk      = cfg_addr_in[7:3];
   assign idx      = cfg_addr_in[2:0];
   assign idx_ok   = (32'(idx) < NBYTES);
   assign wr_cnt   = cfg_wen_in && blk == COUNTER_BASE[7:3] && idx_ok;
   assign wr_match = cfg_wen_in && blk == MATCH_BASE[7:3] && idx_ok;
   assign wr_ctrl  = cfg_wen_in && cfg_addr_in == CTRL_ADDR;
   assign rd_cnt0  = cfg_ren_in && cfg_addr_in == COUNTER_BASE;

   // control register, all fields zero after reset
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
         ctrl_q <= CTRL_RESET;
      else if (wr_ctrl)
         ctrl_q <= cfg_wdata_in;
   end

   // timekeeping reset: held while bit 7 set, then two more cycles
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
         rel_q <= 2'h0;
      else if (ctrl_q[BIT_RTC_RST])
         rel_q <= REL_LOAD;
      else if (rel_q != 2'h0)
         rel_q <= rel_q - 2'h1;
   end

   assign rtc_busy = ctrl_q[BIT_RTC_RST] || (rel_q != 2'h0);
   assign running  = ctrl_q[BIT_CNT_EN] && !rtc_busy;

   // crystal rising-edge detect
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
         xtal_prev_q <= 1'b0;
      else
         xtal_prev_q <= crystal_count_clock_in;
   end

   assign xtal_edge = crystal_count_clock_in && !xtal_prev_q;

   // prescaler, parked so the first wrap needs the start edge count
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in || !running)
         pre_q <= PRE_START;
      else if (xtal_edge)
         pre_q <= pre_q + PRE_W'(1);
   end

   assign tick       = running && xtal_edge && (pre_q == PRE_LAST);
   assign hit        = (cnt_q == match_q);
   assign match_zero = (match_q == '0);
   assign clr_cond   = ctrl_q[BIT_CLR_MATCH] && hit && !match_zero;

   // the counter itself
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in || rtc_busy || !ctrl_q[BIT_CLR_N])
         cnt_q <= '0;
      else if (tick)
      begin
         if (clr_cond)
            cnt_q <= '0;
         else
            cnt_q <= cnt_q + CNT_W'(1);
      end
      else if (wr_cnt && !ctrl_q[BIT_CNT_EN])
         cnt_q[{idx, 3'h0} +: 8] <= cfg_wdata_in;
   end

   // match register, byte writable except while timekeeping reset holds it at zero
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in || rtc_busy)
         match_q <= '0;
      else if (wr_match)
         match_q[{idx, 3'h0} +: 8] <= cfg_wdata_in;
   end

   // hold register caught when the low counter byte is read
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
         hold_q <= '0;
      else if (rd_cnt0)
         hold_q <= cnt_q;
   end

   // match outputs registered, gated by the enable bit
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         fabric_match_out        <= 1'b0;
         power_monitor_match_out <= 1'b0;
      end
      else
      begin
         fabric_match_out        <= ctrl_q[BIT_MATCH_EN] && hit;
         power_monitor_match_out <= ctrl_q[BIT_MATCH_EN] && hit;
      end
   end

   // oscillator controls straight from control flops
   assign osc_mode_out   = ctrl_q[BIT_MODE_HI:BIT_MODE_LO];
   assign osc_select_out = ctrl_q[BIT_XTAL_SEL];

   assign bits_eq = ~(cnt_q ^ match_q);

   // read mux
   always_comb
   begin
      rdata_d = UNMAPPED_READ;
      if (idx_ok && blk == COUNTER_BASE[7:3])
      begin
         if (idx == 3'h0)
            rdata_d = cnt_q[7:0];
         else
            rdata_d = hold_q[{idx, 3'h0} +: 8];
      end
      else if (idx_ok && blk == MATCH_BASE[7:3])
         rdata_d = match_q[{idx, 3'h0} +: 8];
      else if (idx_ok && blk == MATCHBIT_BASE[7:3])
         rdata_d = bits_eq[{idx, 3'h0} +: 8];
      else if (cfg_addr_in == CTRL_ADDR)
         rdata_d = ctrl_q;
   end

   // read data register, updated on each read strobe
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
         rdata_q <= UNMAPPED_READ;
      else if (cfg_ren_in)
         rdata_q <= rdata_d;
   end

   assign cfg_rdata_out = rdata_q;

   // helper: crystal edges seen since enable, for the first tick
   logic [7:0] edg_cnt_q;
   logic       first_q;
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in || !running)
      begin
         edg_cnt_q <= 8'h00;
         first_q   <= 1'b1;
      end
      else if (xtal_edge)
      begin
         if (edg_cnt_q != 8'hFF)
            edg_cnt_q <= edg_cnt_q + 8'h01;
         if (tick)
            first_q <= 1'b0;
      end
   end

   // helper: crystal edges since the previous increment
   logic [15:0] gap_q;
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in || !running || tick)
         gap_q <= 16'h0000;
      else if (xtal_edge && gap_q != 16'hFFFF)
         gap_q <= gap_q + 16'h0001;
   end

   a_rst_release: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $fell(ctrl_q[BIT_RTC_RST]) && !wr_ctrl |-> rtc_busy ##1 rtc_busy ##1 !rtc_busy)
      else $error("timekeeping reset release not two cycles");

   a_count_gate: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !ctrl_q[BIT_CNT_EN] && ctrl_q[BIT_CLR_N] && !rtc_busy && !wr_cnt |=> $stable(cnt_q))
      else $error("counter moved while disabled");

   a_preload_block: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ctrl_q[BIT_CNT_EN] && ctrl_q[BIT_CLR_N] && !rtc_busy && !tick |=> $stable(cnt_q))
      else $error("counter changed by a write while enabled");

   a_first_tick: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      tick && first_q |-> edg_cnt_q == 8'(FIRST_EDG - 1))
      else $error("first increment at wrong edge count");

   a_match_high: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ctrl_q[BIT_MATCH_EN] && hit |=> fabric_match_out && power_monitor_match_out)
      else $error("match outputs not asserted on equality");

   a_match_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !ctrl_q[BIT_MATCH_EN] |=> !fabric_match_out && !power_monitor_match_out)
      else $error("match outputs high while disabled");

   a_clear_match: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      tick && clr_cond && ctrl_q[BIT_CLR_N] |=> cnt_q == '0)
      else $error("counter not cleared on match");

   a_zero_noclear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      tick && match_zero && ctrl_q[BIT_CLR_N] |=> cnt_q == $past(cnt_q) + CNT_W'(1))
      else $error("counter cleared with zero match value");

   a_clear_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !ctrl_q[BIT_CLR_N] |=> cnt_q == '0)
      else $error("counter not cleared by clear bit");

   a_hold_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      rd_cnt0 ##1 (cfg_ren_in && !rd_cnt0 && blk == COUNTER_BASE[7:3] && idx == 3'h1)
      |=> cfg_rdata_out == $past(cnt_q[15:8], 2))
      else $error("held counter byte differs from capture");

   a_prescale_div: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      tick |-> pre_q == PRE_LAST && xtal_edge && (first_q || gap_q == 16'(PRE_DIV - 1)))
      else $error("increment off prescaler wrap");
endmodule

// >>> tb/rcs_xtal_model.sv
// Purpose: crystal clock source and power monitor stand-in
// Assumes: crystal toggles on core clock falling edges, far below core_clk/2
// Notes:   regulator flag latches on a rising power monitor match
`timescale 1ns/1ns
module rcs_xtal_model
#(
   parameter int unsigned HALF_CYC = 4
)
(
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   input  wire logic power_monitor_match_in,
   output logic      crystal_count_clock_out,
   output logic      regulator_on_out
);
   int unsigned div_q   = 0;
   logic        match_q = 1'b0;
   // free running crystal clock
   initial
      crystal_count_clock_out = 1'b0;
   always @(negedge core_clk_in)
   begin
      div_q <= (div_q == HALF_CYC - 1) ? 0 : div_q + 1;
      if (div_q == HALF_CYC - 1)
         crystal_count_clock_out <= ~crystal_count_clock_out;
   end
   // core regulator switches on at a 0 to 1 match transition
   always @(posedge core_clk_in)
   begin
      match_q <= power_monitor_match_in;
      if (!rst_n_in)
         regulator_on_out <= 1'b0;
      else if (power_monitor_match_in && !match_q)
         regulator_on_out <= 1'b1;
   end
endmodule

// >>> tb/test_rtc_control_status_logic.sv
// Purpose: self-checking bench for the timekeeping control/status block
// Assumes: shortened prescaler (8) and start count (4)
// Notes:   crystal clock and power monitor come from the partner model
`timescale 1ns/1ns
module test_rtc_control_status_logic;
   import rcs_pkg::*;
   localparam int unsigned PRE = 8;
   localparam int unsigned FST = 4;
   logic       clk, rst_n, wen, ren, xclk, fmatch, pmatch, osc_sel, reg_on;
   logic [7:0] addr, wdata, rdata, rd;
   logic [1:0] mode;
   int         errors, total_checks;
   `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
      $display("BAD %s exp %h got %h", nm, e, g); end end

   rcs_top #(.CNT_W(40), .PRE_DIV(PRE), .FIRST_EDG(FST)) dut (
      .core_clk_in(clk), .rst_n_in(rst_n), .cfg_addr_in(addr), .cfg_wdata_in(wdata),
      .cfg_wen_in(wen), .cfg_ren_in(ren), .cfg_rdata_out(rdata),
      .crystal_count_clock_in(xclk), .fabric_match_out(fmatch),
      .power_monitor_match_out(pmatch), .osc_mode_out(mode), .osc_select_out(osc_sel));
   rcs_xtal_model xtal (.core_clk_in(clk), .rst_n_in(rst_n), .power_monitor_match_in(pmatch),
      .crystal_count_clock_out(xclk), .regulator_on_out(reg_on));

   // 25 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // verdict and end of run
   task automatic end_sim;
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one-cycle write strobe, then one settle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wen = 1'b1;
      @(negedge clk);
      wen = 1'b0;
      @(negedge clk);
   endtask
   // one-cycle read strobe, data taken a cycle later
   task automatic rdb(input logic [7:0] a);
      @(negedge clk);
      addr = a;
      ren = 1'b1;
      @(negedge clk);
      ren = 1'b0;
      @(negedge clk);
      rd = rdata;
   endtask
   // two read strobes on consecutive edges, each byte taken as it stands
   task automatic rd2(input logic [7:0] a, b, output logic [7:0] d0, d1);
      @(negedge clk);
      addr = a;
      ren = 1'b1;
      @(negedge clk);
      d0 = rdata;
      addr = b;
      @(negedge clk);
      d1 = rdata;
      ren = 1'b0;
   endtask
   // wait n crystal rises, margin before the next one
   task automatic edges(input int n);
      repeat (n) @(posedge xclk);
      repeat (2) @(negedge clk);
   endtask
   // write control just after a crystal fall
   task automatic ctrl_al(input logic [7:0] c);
      @(negedge xclk);
      wr(CTRL_ADDR, c);
   endtask
   // counter value after a run with the given control, then stop
   task automatic run_cnt(input logic [7:0] c, input int n, input logic [7:0] e);
      ctrl_al(c);
      edges(n);
      wr(CTRL_ADDR, 8'h02);
      rdb(COUNTER_BASE);
      `CHK("count", e, rd)
   endtask
   task automatic t_reset;
      rdb(CTRL_ADDR);
      `CHK("ctrl", 8'h00, rd)
      `CHK("match", 2'b00, {fmatch, pmatch})
      `CHK("osc", 3'b000, {mode, osc_sel})
      rdb(8'h60);
      `CHK("unmapped", UNMAPPED_READ, rd)
   endtask
   task automatic t_osc;
      for (int i = 0; i < 4; i++)
      begin
         wr(CTRL_ADDR, {3'b000, 2'(i), 3'b001});
         `CHK("mode", 2'(i), mode)
         `CHK("sel", 1'b1, osc_sel)
      end
      wr(CTRL_ADDR, 8'h18);
      `CHK("sel0", 3'b110, {mode, osc_sel})
   endtask
   task automatic t_count;
      wr(CTRL_ADDR, 8'h02);
      wr(COUNTER_BASE, 8'h05);
      run_cnt(8'h42, FST - 1, 8'h05);
      ctrl_al(8'h42);
      edges(FST + PRE);
      wr(COUNTER_BASE, 8'hAA);
      wr(CTRL_ADDR, 8'h02);
      rdb(COUNTER_BASE);
      `CHK("prescale", 8'h07, rd)
      rdb(COUNTER_BASE + 8'h01);
      `CHK("hold", 8'h00, rd)
      run_cnt(8'hC2, FST, 8'h00);
      wr(COUNTER_BASE, 8'h09);
      rdb(COUNTER_BASE);
      `CHK("release", 8'h09, rd)
   endtask
   task automatic t_match;
      wr(MATCH_BASE, 8'h09);
      `CHK("off", 2'b00, {fmatch, pmatch})
      wr(CTRL_ADDR, 8'h22);
      `CHK("on", 2'b11, {fmatch, pmatch})
      @(negedge clk);
      `CHK("regulator", 1'b1, reg_on)
      wr(COUNTER_BASE, 8'h08);
      run_cnt(8'h66, FST + PRE, 8'h00);
      wr(COUNTER_BASE, 8'h08);
      run_cnt(8'h62, FST + PRE, 8'h0A);
      wr(MATCH_BASE, 8'h00);
      wr(COUNTER_BASE, 8'h00);
      run_cnt(8'h46, FST, 8'h01);
      wr(CTRL_ADDR, 8'h00);
      rdb(COUNTER_BASE);
      `CHK("clear", 8'h00, rd)
   endtask
   // hold capture, match and match-bit read back
   task automatic t_regs;
      logic [7:0] b0, b1;
      wr(CTRL_ADDR, 8'h02);
      wr(COUNTER_BASE + 8'h01, 8'h3C);
      wr(COUNTER_BASE, 8'h11);
      rd2(COUNTER_BASE, COUNTER_BASE + 8'h01, b0, b1);
      `CHK("live0", 8'h11, b0)
      `CHK("held1", 8'h3C, b1)
      wr(COUNTER_BASE + 8'h01, 8'h77);
      rdb(COUNTER_BASE + 8'h01);
      `CHK("frozen1", 8'h3C, rd)
      wr(MATCH_BASE + 8'h01, 8'h77);
      rdb(MATCH_BASE + 8'h01);
      `CHK("matchreg1", 8'h77, rd)
      rdb(MATCHBIT_BASE + 8'h01);
      `CHK("matchbit1", 8'hFF, rd)
      wr(MATCHBIT_BASE, 8'h00);
      rdb(MATCHBIT_BASE);
      `CHK("matchbit0", 8'hEE, rd)
   endtask
   // reset in mid-run with every control output driven high
   task automatic t_rst2;
      wr(MATCH_BASE, 8'h11);
      wr(CTRL_ADDR, 8'h3B);
      `CHK("pre osc", 3'b111, {mode, osc_sel})
      `CHK("pre match", 2'b11, {fmatch, pmatch})
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      `CHK("rst osc", 3'b000, {mode, osc_sel})
      `CHK("rst match", 2'b00, {fmatch, pmatch})
      rdb(CTRL_ADDR);
      `CHK("rst ctrl", 8'h00, rd)
      rdb(MATCH_BASE);
      `CHK("rst matchreg", 8'h00, rd)
   endtask
   // watchdog against a hang
   initial
   begin
      #(40 * 20000);
      errors++;
      end_sim();
   end
   // main sequence
   initial
   begin
      errors = 0;
      total_checks = 0;
      rst_n = 1'b0;
      wen = 1'b0;
      ren = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_osc();
      t_count();
      t_match();
      t_regs();
      t_rst2();
      end_sim();
   end
endmodule
